/* File: rtl/itcst_defines.vh */
`ifndef ITCST_DEFINES_VH
`define ITCST_DEFINES_VH

// command codes
`define ITCST_CMD_CLEAR_FAULTS 8'h03
`define ITCST_CMD_INPUT_FAULTS 8'h7c
`define ITCST_CMD_TEMP_FAULTS 8'h7d
`define ITCST_CMD_CML_FAULTS 8'h7e
`define ITCST_CMD_VENDOR_FLAGS 8'h80
`define ITCST_CMD_VIN_READING 8'h88
`define ITCST_CMD_IIN_READING 8'h89

// input_fault_summary field positions and used-bit mask
`define ITCST_IN_VIN_OV 7
`define ITCST_IN_VIN_UV 4
`define ITCST_IN_IIN_OC 2
`define ITCST_IN_USED 8'h94

// temperature_fault_summary field positions and used-bit mask
`define ITCST_TMP_OT_FAULT 7
`define ITCST_TMP_OT_WARN 6
`define ITCST_TMP_UT_FAULT 4
`define ITCST_TMP_USED 8'hd0

// comm_logic_memory_faults field positions and used-bit mask
`define ITCST_CML_BAD_CMD 7
`define ITCST_CML_BAD_DATA 6
`define ITCST_CML_PEC 5
`define ITCST_CML_MEM 4
`define ITCST_CML_PROC 3
`define ITCST_CML_COMM_OTHER 1
`define ITCST_CML_LOGIC_OTHER 0
`define ITCST_CML_USED 8'hfb

// vendor_status_flags field positions and used-bit mask
`define ITCST_VND_OTP_FULL 1
`define ITCST_VND_USED 8'h02

// reset values
`define ITCST_STATUS_RST 8'h00
`define ITCST_READING_RST 16'h0000

// response lengths in data bytes
`define ITCST_LEN_NONE 2'h0
`define ITCST_LEN_BYTE 2'h1
`define ITCST_LEN_WORD 2'h2

`endif

/* File: rtl/itcst_sticky.v */
`timescale 1ns/1ps
`include "itcst_defines.vh"

// one status byte of sticky flags, unused positions forced to zero
module itcst_sticky
#(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] USED = {WIDTH{1'b1}}
)
(
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // events and clear
  input wire [WIDTH-1:0] i_set,
  input wire i_clr,
  // flag state
  output wire [WIDTH-1:0] o_flags,
  output wire [WIDTH-1:0] o_flags_next
);

reg [WIDTH-1:0] flags_q;
wire [WIDTH-1:0] flags_d;

// set is or-ed after the clear so an event in the clearing cycle survives
assign flags_d = ((i_clr ? {WIDTH{1'b0}} : flags_q) | i_set) & USED;

// flag storage
always @(posedge i_clk or negedge i_rst_b)
begin
  if (!i_rst_b)
  begin
    flags_q <= {WIDTH{1'b0}};
  end
  else
  begin
    flags_q <= flags_d;
  end
end

assign o_flags = flags_q;
assign o_flags_next = flags_d;

endmodule

/* File: rtl/itcst_top.v */
`timescale 1ns/1ps
`include "itcst_defines.vh"

module itcst_top
#(
  parameter READING_WIDTH = 16
)
(
  // clock and reset
  input wire I_CLOCK,
  input wire I_RST_B,
  // command port, one decoded transaction per strobe
  input wire I_CMD_VALID,
  input wire [7:0] I_CMD_CODE,
  input wire I_CMD_READ,
  input wire [1:0] I_CMD_NBYTES,
  input wire I_CMD_PEC_ERR,
  // response to each transaction
  output wire O_RSP_VALID,
  output wire O_RSP_NACK,
  output wire [1:0] O_RSP_LEN,
  output wire [15:0] O_RSP_DATA,
  // input supply fault detectors
  input wire I_VIN_OV,
  input wire I_VIN_UV,
  input wire I_IIN_OC,
  // temperature detectors
  input wire I_OT_FAULT,
  input wire I_OT_WARN,
  input wire I_UT_FAULT,
  // memory, processor and other fault sources
  input wire I_MEM_FAULT,
  input wire I_PROC_FAULT,
  input wire I_COMM_OTHER,
  input wire I_LOGIC_OTHER,
  input wire I_OTP_FULL,
  // telemetry samples
  input wire I_TLM_VALID,
  input wire [READING_WIDTH-1:0] I_VIN_MV,
  input wire [READING_WIDTH-1:0] I_IIN_CNT,
  // summary bits for the status byte and word
  output wire O_WORD_INPUT,
  output wire O_WORD_VENDOR,
  output wire O_BYTE_TEMP,
  output wire O_BYTE_CML
);

// command classification
wire cmd_known;
wire [1:0] cmd_len;
wire cmd_is_clear;
wire cmd_take;

// per-register event vectors
reg [7:0] in_set;
reg [7:0] tmp_set;
reg [7:0] cml_set;
reg [7:0] vnd_set;
reg clr_all;

// status flags and their next values
wire [7:0] in_flags;
wire [7:0] in_next;
wire [7:0] tmp_flags;
wire [7:0] tmp_next;
wire [7:0] cml_flags;
wire [7:0] cml_next;
wire [7:0] vnd_flags;
wire [7:0] vnd_next;

// telemetry snapshots
reg [READING_WIDTH-1:0] vin_q;
reg [READING_WIDTH-1:0] iin_q;

// response registers
reg rsp_valid_q;
reg rsp_valid_d;
reg rsp_nack_q;
reg rsp_nack_d;
reg [1:0] rsp_len_q;
reg [1:0] rsp_len_d;
reg [15:0] rsp_data_q;
reg [15:0] rsp_data_d;

// summary registers
reg word_input_q;
reg word_vendor_q;
reg byte_temp_q;
reg byte_cml_q;

// data bytes returned by a read of a code, zero for non-readable codes
function [1:0] read_len;
  input [7:0] code;
  begin
    case (code)
      `ITCST_CMD_INPUT_FAULTS: read_len = `ITCST_LEN_BYTE;
      `ITCST_CMD_TEMP_FAULTS: read_len = `ITCST_LEN_BYTE;
      `ITCST_CMD_CML_FAULTS: read_len = `ITCST_LEN_BYTE;
      `ITCST_CMD_VENDOR_FLAGS: read_len = `ITCST_LEN_BYTE;
      `ITCST_CMD_VIN_READING: read_len = `ITCST_LEN_WORD;
      `ITCST_CMD_IIN_READING: read_len = `ITCST_LEN_WORD;
      default: read_len = `ITCST_LEN_NONE;
    endcase
  end
endfunction

// sign-extend a reading into the 16-bit response word
function [15:0] to_word;
  input [READING_WIDTH-1:0] value;
  reg [31:0] ext;
  begin
    ext = {{(32-READING_WIDTH){value[READING_WIDTH-1]}}, value};
    to_word = ext[15:0];
  end
endfunction

assign cmd_len = read_len(I_CMD_CODE);
assign cmd_is_clear = (I_CMD_CODE == `ITCST_CMD_CLEAR_FAULTS);
assign cmd_known = cmd_is_clear || (cmd_len != `ITCST_LEN_NONE);
// a transaction with a bad check byte is not executed: it only sets the packet bit and gets a nack
assign cmd_take = I_CMD_VALID && !I_CMD_PEC_ERR;

// detector levels into the fault registers, held while present
always @*
begin
  in_set = 8'h00;
  tmp_set = 8'h00;
  vnd_set = 8'h00;
  in_set[`ITCST_IN_VIN_OV] = I_VIN_OV;
  in_set[`ITCST_IN_VIN_UV] = I_VIN_UV;
  in_set[`ITCST_IN_IIN_OC] = I_IIN_OC;
  tmp_set[`ITCST_TMP_OT_FAULT] = I_OT_FAULT;
  tmp_set[`ITCST_TMP_OT_WARN] = I_OT_WARN;
  tmp_set[`ITCST_TMP_UT_FAULT] = I_UT_FAULT;
  vnd_set[`ITCST_VND_OTP_FULL] = I_OTP_FULL;
end

// command checking and communication, memory and logic events
always @*
begin
  cml_set = 8'h00;
  clr_all = 1'b0;
  cml_set[`ITCST_CML_MEM] = I_MEM_FAULT;
  cml_set[`ITCST_CML_PROC] = I_PROC_FAULT;
  cml_set[`ITCST_CML_COMM_OTHER] = I_COMM_OTHER;
  cml_set[`ITCST_CML_LOGIC_OTHER] = I_LOGIC_OTHER;
  if (I_CMD_VALID && I_CMD_PEC_ERR)
  begin
    cml_set[`ITCST_CML_PEC] = 1'b1;
  end
  else if (cmd_take && !cmd_known)
  begin
    cml_set[`ITCST_CML_BAD_CMD] = 1'b1;
  end
  else if (cmd_take && cmd_is_clear)
  begin
    // clear is a send-byte command: no data, no read
    if (I_CMD_READ || (I_CMD_NBYTES != 2'h0))
    begin
      cml_set[`ITCST_CML_BAD_DATA] = 1'b1;
    end
    else
    begin
      clr_all = 1'b1;
    end
  end
  else if (cmd_take && !I_CMD_READ)
  begin
    // read-only codes refuse any write and keep their contents
    cml_set[`ITCST_CML_BAD_DATA] = 1'b1;
  end
end

// input fault byte, global so no page selects it
itcst_sticky
#(
  .WIDTH(8),
  .USED(`ITCST_IN_USED)
)
u_in_flags
(
  .i_clk(I_CLOCK),
  .i_rst_b(I_RST_B),
  .i_set(in_set),
  .i_clr(clr_all),
  .o_flags(in_flags),
  .o_flags_next(in_next)
);

// temperature fault byte
itcst_sticky
#(
  .WIDTH(8),
  .USED(`ITCST_TMP_USED)
)
u_tmp_flags
(
  .i_clk(I_CLOCK),
  .i_rst_b(I_RST_B),
  .i_set(tmp_set),
  .i_clr(clr_all),
  .o_flags(tmp_flags),
  .o_flags_next(tmp_next)
);

// communication, memory and logic byte, bit 2 unused
itcst_sticky
#(
  .WIDTH(8),
  .USED(`ITCST_CML_USED)
)
u_cml_flags
(
  .i_clk(I_CLOCK),
  .i_rst_b(I_RST_B),
  .i_set(cml_set),
  .i_clr(clr_all),
  .o_flags(cml_flags),
  .o_flags_next(cml_next)
);

// vendor byte, only the otp-full bit is live
itcst_sticky
#(
  .WIDTH(8),
  .USED(`ITCST_VND_USED)
)
u_vnd_flags
(
  .i_clk(I_CLOCK),
  .i_rst_b(I_RST_B),
  .i_set(vnd_set),
  .i_clr(clr_all),
  .o_flags(vnd_flags),
  .o_flags_next(vnd_next)
);

// telemetry snapshots, replaced whole so a read never mixes two samples
always @(posedge I_CLOCK or negedge I_RST_B)
begin
  if (!I_RST_B)
  begin
    vin_q <= `ITCST_READING_RST;
    iin_q <= `ITCST_READING_RST;
  end
  else if (I_TLM_VALID)
  begin
    vin_q <= I_VIN_MV;
    iin_q <= I_IIN_CNT;
  end
end

// response decode; a refused transaction returns no data
always @*
begin
  rsp_valid_d = I_CMD_VALID;
  rsp_nack_d = 1'b0;
  rsp_len_d = `ITCST_LEN_NONE;
  rsp_data_d = 16'h0000;
  if (!I_CMD_VALID)
  begin
    rsp_valid_d = 1'b0;
  end
  else if (I_CMD_PEC_ERR || !cmd_known)
  begin
    rsp_nack_d = 1'b1;
  end
  else if (cmd_is_clear)
  begin
    rsp_nack_d = I_CMD_READ || (I_CMD_NBYTES != 2'h0);
  end
  else if (!I_CMD_READ)
  begin
    rsp_nack_d = 1'b1;
  end
  else
  begin
    rsp_len_d = cmd_len;
    case (I_CMD_CODE)
      `ITCST_CMD_INPUT_FAULTS: rsp_data_d = {8'h00, in_flags};
      `ITCST_CMD_TEMP_FAULTS: rsp_data_d = {8'h00, tmp_flags};
      `ITCST_CMD_CML_FAULTS: rsp_data_d = {8'h00, cml_flags};
      `ITCST_CMD_VENDOR_FLAGS: rsp_data_d = {8'h00, vnd_flags};
      `ITCST_CMD_VIN_READING: rsp_data_d = to_word(vin_q);
      `ITCST_CMD_IIN_READING: rsp_data_d = to_word(iin_q);
      default: rsp_data_d = 16'h0000;
    endcase
  end
end

// response registers, one cycle after the strobe
always @(posedge I_CLOCK or negedge I_RST_B)
begin
  if (!I_RST_B)
  begin
    rsp_valid_q <= 1'b0;
    rsp_nack_q <= 1'b0;
    rsp_len_q <= `ITCST_LEN_NONE;
    rsp_data_q <= 16'h0000;
  end
  else
  begin
    rsp_valid_q <= rsp_valid_d;
    rsp_nack_q <= rsp_nack_d;
    rsp_len_q <= rsp_len_d;
    rsp_data_q <= rsp_data_d;
  end
end

// summaries track the next flag values so they change with the flags
always @(posedge I_CLOCK or negedge I_RST_B)
begin
  if (!I_RST_B)
  begin
    word_input_q <= 1'b0;
    word_vendor_q <= 1'b0;
    byte_temp_q <= 1'b0;
    byte_cml_q <= 1'b0;
  end
  else
  begin
    word_input_q <= |in_next;
    word_vendor_q <= |vnd_next;
    byte_temp_q <= |tmp_next;
    byte_cml_q <= |cml_next;
  end
end

// outputs straight from flops
assign O_RSP_VALID = rsp_valid_q;
assign O_RSP_NACK = rsp_nack_q;
assign O_RSP_LEN = rsp_len_q;
assign O_RSP_DATA = rsp_data_q;
assign O_WORD_INPUT = word_input_q;
assign O_WORD_VENDOR = word_vendor_q;
assign O_BYTE_TEMP = byte_temp_q;
assign O_BYTE_CML = byte_cml_q;

endmodule

/* File: tb/itcst_monitor.sv */
`timescale 1ns/1ps
// watches answers and summary bits at the top ports
module itcst_monitor
(
  // clock, reset, command
  input wire I_CLOCK,
  input wire I_RST_B,
  input wire I_CMD_VALID,
  input wire [7:0] I_CMD_CODE,
  input wire I_CMD_READ,
  input wire I_CMD_PEC_ERR,
  // answer
  input wire O_RSP_VALID,
  input wire O_RSP_NACK,
  input wire [1:0] O_RSP_LEN,
  input wire [15:0] O_RSP_DATA,
  // sources and summaries
  input wire I_VIN_OV,
  input wire I_OT_WARN,
  input wire I_MEM_FAULT,
  input wire I_OTP_FULL,
  input wire O_WORD_INPUT,
  input wire O_WORD_VENDOR,
  input wire O_BYTE_TEMP,
  input wire O_BYTE_CML
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  // clear attempts excuse the summary from holding
  wire clr = I_CMD_VALID && !I_CMD_READ && I_CMD_CODE == 8'h03;
  wire rd_in = I_CMD_VALID && I_CMD_READ && !I_CMD_PEC_ERR && I_CMD_CODE == 8'h7c;
  AST_RSP_NEXT: assert property (I_CMD_VALID |=> O_RSP_VALID)
    else $error("no answer");
  AST_PEC: assert property (I_CMD_VALID && I_CMD_PEC_ERR |=> O_RSP_NACK && O_BYTE_CML)
    else $error("packet error missed");
  AST_BAD_CMD: assert property (I_CMD_VALID && I_CMD_CODE == 8'h7f |=> O_RSP_NACK && O_BYTE_CML)
    else $error("unknown code accepted");
  AST_IN_BYTE: assert property (rd_in |=> O_RSP_LEN == 2'h1 && (O_RSP_DATA & 16'hff6b) == 16'h0)
    else $error("input byte shape");
  AST_OV: assert property (I_VIN_OV |=> O_WORD_INPUT)
    else $error("input summary late");
  AST_WARN: assert property (I_OT_WARN |=> O_BYTE_TEMP)
    else $error("temp summary late");
  AST_MEM: assert property (I_MEM_FAULT |=> O_BYTE_CML)
    else $error("cml summary late");
  AST_OTP: assert property (I_OTP_FULL |=> O_WORD_VENDOR)
    else $error("vendor summary late");
  AST_STICKY: assert property (O_WORD_INPUT && !clr |=> O_WORD_INPUT)
    else $error("input flag lost");
  cover property (rd_in);
  cover property (I_CMD_VALID && I_CMD_PEC_ERR);
  cover property (O_RSP_VALID && O_RSP_LEN == 2'h2);
endmodule

bind itcst_top itcst_monitor mon_u (.*);

/* File: tb/itcst_host.sv */
`timescale 1ns/1ps
// host side: one decoded transaction, answer collected
module itcst_host
(
  // clock
  input wire i_clk,
  // request
  output reg o_v,
  output reg [7:0] o_code,
  output reg o_rd,
  output reg [1:0] o_nb,
  output reg o_pec,
  // answer
  input wire i_v,
  input wire i_k,
  input wire [1:0] i_l,
  input wire [15:0] i_d
);
  initial {o_v, o_code, o_rd, o_nb, o_pec} = 13'h0;
  // released lines show the inverse so stale values never look valid
  task xfer(input [7:0] c, input r, input [1:0] n, input p,
    output ok, output k, output [1:0] l, output [15:0] d);
    integer i;
    begin
      @(posedge i_clk);
      o_v <= 1'b1;
      {o_code, o_rd, o_nb, o_pec} <= {c, r, n, p};
      @(posedge i_clk);
      o_v <= 1'b0;
      {o_code, o_rd, o_nb, o_pec} <= ~{c, r, n, p};
      ok = 1'b0;
      for (i = 0; i < 4 && !ok; i = i + 1)
      begin
        @(posedge i_clk);
        ok = (i_v === 1'b1);
      end
      {k, l, d} = {i_k, i_l, i_d};
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [10:0] flt = 11'h0;
  reg tv = 1'b0;
  reg [15:0] vin = 16'h0;
  reg [15:0] iin = 16'h0;
  wire cv, crd, cpec, rv, rk, wi, wv, bt, bc;
  wire [7:0] cc;
  wire [1:0] cn, rl;
  wire [15:0] rdat;
  integer error_cnt = 0;
  integer n_compared = 0;
  // per source: code, expected byte, summary {input, vendor, temp, cml}
  reg [219:0] tbl = {20'h7c808, 20'h7c108, 20'h7c048, 20'h7d802, 20'h7d402,
    20'h7d102, 20'h7e101, 20'h7e081, 20'h7e021, 20'h7e011, 20'h80024};

  itcst_top dut_u (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_CMD_VALID(cv), .I_CMD_CODE(cc), .I_CMD_READ(crd),
    .I_CMD_NBYTES(cn), .I_CMD_PEC_ERR(cpec), .O_RSP_VALID(rv), .O_RSP_NACK(rk),
    .O_RSP_LEN(rl), .O_RSP_DATA(rdat), .I_VIN_OV(flt[10]), .I_VIN_UV(flt[9]),
    .I_IIN_OC(flt[8]), .I_OT_FAULT(flt[7]), .I_OT_WARN(flt[6]), .I_UT_FAULT(flt[5]),
    .I_MEM_FAULT(flt[4]), .I_PROC_FAULT(flt[3]), .I_COMM_OTHER(flt[2]),
    .I_LOGIC_OTHER(flt[1]), .I_OTP_FULL(flt[0]), .I_TLM_VALID(tv), .I_VIN_MV(vin),
    .I_IIN_CNT(iin), .O_WORD_INPUT(wi), .O_WORD_VENDOR(wv), .O_BYTE_TEMP(bt),
    .O_BYTE_CML(bc));
  itcst_host host_u (.i_clk(clk), .o_v(cv), .o_code(cc), .o_rd(crd), .o_nb(cn),
    .o_pec(cpec), .i_v(rv), .i_k(rk), .i_l(rl), .i_d(rdat));

  initial forever #25 clk = ~clk;

  task chk(input [15:0] s, input [15:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t seen %h exp %h", $time, s, e);
      end
    end
  endtask

  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // one transaction; a missing answer ends the run
  task xact(input [7:0] c, input r, input [1:0] n, input p,
    input k, input [1:0] l, input [15:0] d);
    reg ok, gk;
    reg [1:0] gl;
    reg [15:0] gd;
    begin
      host_u.xfer(c, r, n, p, ok, gk, gl, gd);
      if (!ok)
      begin
        error_cnt = error_cnt + 1;
        complete_run;
      end
      else
      begin
        chk({15'h0, gk}, {15'h0, k});
        chk({14'h0, gl}, {14'h0, l});
        chk(gd, d);
      end
    end
  endtask

  task t_reset;
    integer i;
    reg [47:0] cds;
    begin
      cds = 48'h7c7d7e808889;
      for (i = 0; i < 6; i = i + 1)
        xact(cds[47-8*i -: 8], 1'b1, 2'h0, 1'b0, 1'b0, (i < 4) ? 2'h1 : 2'h2, 16'h0);
      chk({12'h0, wi, wv, bt, bc}, 16'h0);
      $display("reset values done");
    end
  endtask

  // each source alone: its bit, its summary, then a clear
  task t_flt;
    integer i;
    reg [19:0] e;
    begin
      for (i = 0; i < 11; i = i + 1)
      begin
        e = tbl[219-20*i -: 20];
        @(posedge clk) flt <= 11'h400 >> i;
        @(posedge clk) flt <= 11'h0;
        xact(e[19:12], 1'b1, 2'h0, 1'b0, 1'b0, 2'h1, {8'h0, e[11:4]});
        chk({12'h0, wi, wv, bt, bc}, {12'h0, e[3:0]});
        xact(8'h03, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 16'h0);
        xact(e[19:12], 1'b1, 2'h0, 1'b0, 1'b0, 2'h1, 16'h0);
      end
      $display("fault sources done");
    end
  endtask

  // refused transactions and the bits they leave behind
  task t_cmd;
    begin
      xact(8'h7f, 1'b1, 2'h0, 1'b0, 1'b1, 2'h0, 16'h0);
      xact(8'h7e, 1'b1, 2'h0, 1'b0, 1'b0, 2'h1, 16'h0080);
      xact(8'h03, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 16'h0);
      xact(8'h7c, 1'b0, 2'h1, 1'b0, 1'b1, 2'h0, 16'h0);
      xact(8'h88, 1'b0, 2'h2, 1'b0, 1'b1, 2'h0, 16'h0);
      xact(8'h7e, 1'b1, 2'h0, 1'b0, 1'b0, 2'h1, 16'h0040);
      xact(8'h7c, 1'b1, 2'h0, 1'b1, 1'b1, 2'h0, 16'h0);
      xact(8'h7e, 1'b1, 2'h0, 1'b0, 1'b0, 2'h1, 16'h0060);
      chk({15'h0, bc}, 16'h1);
      xact(8'h03, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 16'h0);
      xact(8'h7c, 1'b1, 2'h0, 1'b0, 1'b0, 2'h1, 16'h0);
      // clear carrying data or asked as a read is refused and clears nothing
      xact(8'h03, 1'b0, 2'h1, 1'b0, 1'b1, 2'h0, 16'h0);
      xact(8'h03, 1'b1, 2'h0, 1'b0, 1'b1, 2'h0, 16'h0);
      xact(8'h7e, 1'b1, 2'h0, 1'b0, 1'b0, 2'h1, 16'h0040);
      xact(8'h03, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 16'h0);
      // a bad check byte hides the unknown code: only the packet bit
      xact(8'h7f, 1'b1, 2'h0, 1'b1, 1'b1, 2'h0, 16'h0);
      xact(8'h7e, 1'b1, 2'h0, 1'b0, 1'b0, 2'h1, 16'h0020);
      $display("command errors done");
    end
  endtask

  // readings latch on the sample strobe and hold after it
  task t_tlm;
    begin
      @(posedge clk) {tv, vin, iin} <= {1'b1, 16'hd8f0, 16'h04d2};
      @(posedge clk) {tv, vin, iin} <= 33'h0;
      xact(8'h88, 1'b1, 2'h0, 1'b0, 1'b0, 2'h2, 16'hd8f0);
      xact(8'h89, 1'b1, 2'h0, 1'b0, 1'b0, 2'h2, 16'h04d2);
      $display("telemetry done");
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_flt;
    t_cmd;
    t_tlm;
    complete_run;
  end
endmodule
